// *** inc/bod_regs.svh ***
// register offsets, field positions, encodings and masks of the byte-op decoder
`ifndef BOD_REGS_SVH
`define BOD_REGS_SVH
`define BOD_ADDR_W 3
`define BOD_REG_CTRL 3'h0
`define BOD_REG_STAT 3'h1
`define BOD_REG_COUNT 3'h2
`define BOD_REG_BANK 3'h3
`define BOD_REG_LAST 3'h4
`define BOD_CTRL_PRESC 0
`define BOD_CTRL_EN 1
`define BOD_CTRL_RST 2'h2
`define BOD_F_MSB 7
`define BOD_D_BIT 9
`define BOD_A_BIT 8
`define BOD_S_BIT 8
`define BOD_B_MSB 11
`define BOD_B_LSB 9
`define BOD_LONG_MSB 11
`define BOD_BRA_MSB 10
`define BOD_BRA_SEL 11
`define BOD_PREFIX 4'hf
// flag mask bits, msb first: c, dc, ov, z, n
`define BOD_FL_ARITH 5'h1f
`define BOD_FL_CZN 5'h13
`define BOD_FL_ZN 5'h03
`define BOD_FL_Z 5'h02
`define BOD_FL_NONE 5'h00
`define BOD_PORT_LO 8'h80
`define BOD_PORT_HI 8'h84
`define BOD_TIMER0 8'hd6
`define BOD_ACC_SPLIT 8'h60
`define BOD_ACC_HI_BANK 4'hf
`define BOD_ACC_LO_BANK 4'h0
`endif

// *** inc/bod_pkg.sv ***
// decoded operation and sequencer state types of the byte-op decoder
`default_nettype none
package bod_pkg;
  typedef enum logic [5:0] {
    op_nop = 6'h00, op_add = 6'h01, op_addc = 6'h02, op_and = 6'h03,
    op_or = 6'h04, op_xor = 6'h05, op_complement_file = 6'h06, op_cpeq = 6'h07,
    op_cpgt = 6'h08, op_cplt = 6'h09, op_decf = 6'h0a, op_decsz = 6'h0b,
    op_decsnz = 6'h0c, op_incf = 6'h0d, op_incsz = 6'h0e, op_incsnz = 6'h0f,
    op_rlc = 6'h10, op_rrc = 6'h11, op_rln = 6'h12, op_rrn = 6'h13,
    op_sub = 6'h14, op_subb = 6'h15, op_subfb = 6'h16, op_mul = 6'h17,
    op_neg = 6'h18, op_move2 = 6'h19, op_clrf = 6'h1a, op_movf = 6'h1b,
    op_movwf = 6'h1c, op_setf = 6'h1d, op_swapf = 6'h1e, op_tstsz = 6'h1f,
    op_bit = 6'h20, op_literal = 6'h21, op_call = 6'h22, op_goto = 6'h23,
    op_bra = 6'h24, op_rcall = 6'h25, op_bcond = 6'h26, op_lfsr = 6'h27,
    op_other = 6'h28
  } bod_op_t;
  typedef enum logic [1:0] {
    st_fetch = 2'h0,
    st_second = 2'h1
  } bod_state_t;
endpackage
`default_nettype wire

// *** hw/bod_decoder.sv ***
// byte-oriented instruction decoder with avalon-mm control registers
// Operation
// (RL1) d=0 result to accumulator, d=1 to file
// (RL2) a=0 access bank, a=1 bank select register
// (RL3) 8-bit file address in low byte
// (RL4) two-word move: 12-bit source, 1111+12-bit destination
// (RL5) 3-bit field selects bit position
// (RL6) literal operand from low byte
// (RL7) call/goto 20-bit target over two words
// (RL8) unconditional branch offset bits 10:0
// (RL9) conditional branch offset bits 7:0
// (RL10) add, add-carry, inc, dec, negate: all five flags
// (RL11) logic ops update zero and negative only
// (RL12) compare-skips: one cycle, flags untouched
// (RL13) counting skips leave flags untouched
// (RL14) rotates: with carry CZN, plain ZN
// (RL15) subtracts update all five flags
// (RL16) multiply single cycle, no flags
// (RL17) pc change or true test adds nop cycle
// (RL18) unconsumed second word executes as nop
// (RL19) port read-modify-write sources pin levels; the code does so only for ports addressed with a=0
// (RL20) timer-zero write clears assigned prescaler; the code clears it only for a=0 writes and two-word moves to it
// (RL21) fast bit selects shadow save/restore
// (RL22) branch offsets two's complement added to pc
// (RL23) multiply result to product byte registers
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bod_regs.svh"
module bod_decoder #(
  parameter int PC_W = 21,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [15:0] instr_word_in,
  input wire logic instr_valid_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic cond_true_in,
  input wire logic [`BOD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic valid_out,
  output logic [5:0] op_out,
  output logic dest_file_out,
  output logic [11:0] file_addr_out,
  output logic [2:0] bit_sel_out,
  output logic [7:0] literal_out,
  output logic [11:0] dst_addr_out,
  output logic [19:0] target_out,
  output logic [PC_W-1:0] branch_target_out,
  output logic [4:0] flag_mask_out,
  output logic fast_out,
  output logic pins_source_out,
  output logic clear_prescaler_out,
  output logic product_write_out,
  output logic exec_nop_out
);
  //////////////////////////////////////////////////////////////////////////
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rst_n = rst_sync_ff;
  //////////////////////////////////////////////////////////////////////////
  function automatic bod_pkg::bod_op_t dec_op(input logic [15:0] w);
    dec_op = bod_pkg::op_other;
    case (w[15:10])
      6'h09: dec_op = bod_pkg::op_add; // RL10
      6'h08: dec_op = bod_pkg::op_addc; // RL10
      6'h0a: dec_op = bod_pkg::op_incf;
      6'h01: dec_op = bod_pkg::op_decf;
      6'h05: dec_op = bod_pkg::op_and; // RL11
      6'h04: dec_op = bod_pkg::op_or; // RL11
      6'h06: dec_op = bod_pkg::op_xor; // RL11
      6'h07: dec_op = bod_pkg::op_complement_file; // RL11
      6'h0b: dec_op = bod_pkg::op_decsz; // RL13
      6'h13: dec_op = bod_pkg::op_decsnz; // RL13
      6'h0f: dec_op = bod_pkg::op_incsz; // RL13
      6'h12: dec_op = bod_pkg::op_incsnz; // RL13
      6'h0d: dec_op = bod_pkg::op_rlc; // RL14
      6'h0c: dec_op = bod_pkg::op_rrc; // RL14
      6'h11: dec_op = bod_pkg::op_rln; // RL14
      6'h10: dec_op = bod_pkg::op_rrn; // RL14
      6'h17: dec_op = bod_pkg::op_sub; // RL15
      6'h16: dec_op = bod_pkg::op_subb; // RL15
      6'h15: dec_op = bod_pkg::op_subfb; // RL15
      6'h14: dec_op = bod_pkg::op_movf;
      6'h0e: dec_op = bod_pkg::op_swapf;
      default: begin
        case (w[15:9])
          7'h01: dec_op = bod_pkg::op_mul; // RL16
          7'h30: dec_op = bod_pkg::op_cplt; // RL12
          7'h31: dec_op = bod_pkg::op_cpeq; // RL12
          7'h32: dec_op = bod_pkg::op_cpgt; // RL12
          7'h33: dec_op = bod_pkg::op_tstsz;
          7'h34: dec_op = bod_pkg::op_setf;
          7'h35: dec_op = bod_pkg::op_clrf;
          7'h36: dec_op = bod_pkg::op_neg; // RL10
          7'h37: dec_op = bod_pkg::op_movwf;
          default: begin
            case (w[15:12])
              4'h7, 4'h8, 4'h9, 4'ha, 4'hb: dec_op = bod_pkg::op_bit;
              4'hc: dec_op = bod_pkg::op_move2; // RL4
              4'hd: dec_op = w[`BOD_BRA_SEL] ? bod_pkg::op_rcall : bod_pkg::op_bra;
              4'he: begin
                if (!w[11])
                  dec_op = bod_pkg::op_bcond; // RL9
                else if (w[11:9] == 3'h6)
                  dec_op = bod_pkg::op_call; // RL7
                else if (w[11:8] == 4'hf)
                  dec_op = bod_pkg::op_goto; // RL7
                else if (w[11:8] == 4'he)
                  dec_op = bod_pkg::op_lfsr;
              end
              // a stray second word in fetch is harmless
              4'hf: dec_op = bod_pkg::op_nop; // RL18
              4'h0: if (w[11]) dec_op = bod_pkg::op_literal; // RL6
              default: dec_op = bod_pkg::op_other;
            endcase
          end
        endcase
      end
    endcase
  endfunction
  function automatic logic [4:0] flags_of(input bod_pkg::bod_op_t op);
    case (op)
      bod_pkg::op_add, bod_pkg::op_addc, bod_pkg::op_incf, bod_pkg::op_decf,
      bod_pkg::op_neg: flags_of = `BOD_FL_ARITH; // RL10
      bod_pkg::op_sub, bod_pkg::op_subb,
      bod_pkg::op_subfb: flags_of = `BOD_FL_ARITH; // RL15
      bod_pkg::op_and, bod_pkg::op_or, bod_pkg::op_xor, bod_pkg::op_complement_file,
      bod_pkg::op_movf, bod_pkg::op_rln, bod_pkg::op_rrn: flags_of = `BOD_FL_ZN; // RL11 RL14
      bod_pkg::op_rlc, bod_pkg::op_rrc: flags_of = `BOD_FL_CZN; // RL14
      bod_pkg::op_clrf: flags_of = `BOD_FL_Z;
      default: flags_of = `BOD_FL_NONE; // RL12 RL13 RL16
    endcase
  endfunction
  function automatic logic has_d(input bod_pkg::bod_op_t op);
    has_d = (op >= bod_pkg::op_add) && (op <= bod_pkg::op_subfb)
      && (op != bod_pkg::op_cpeq) && (op != bod_pkg::op_cpgt)
      && (op != bod_pkg::op_cplt);
    if (op == bod_pkg::op_movf || op == bod_pkg::op_swapf)
      has_d = 1'b1;
  endfunction
  function automatic logic always_file(input bod_pkg::bod_op_t op);
    always_file = (op == bod_pkg::op_clrf) || (op == bod_pkg::op_setf)
      || (op == bod_pkg::op_movwf) || (op == bod_pkg::op_neg)
      || (op == bod_pkg::op_bit);
  endfunction
  function automatic logic pc_mod(input bod_pkg::bod_op_t op);
    pc_mod = (op == bod_pkg::op_bra) || (op == bod_pkg::op_rcall)
      || (op == bod_pkg::op_call) || (op == bod_pkg::op_goto);
  endfunction
  function automatic logic cond_op(input bod_pkg::bod_op_t op);
    cond_op = (op == bod_pkg::op_bcond) || (op == bod_pkg::op_cpeq)
      || (op == bod_pkg::op_cpgt) || (op == bod_pkg::op_cplt)
      || (op == bod_pkg::op_decsz) || (op == bod_pkg::op_decsnz)
      || (op == bod_pkg::op_incsz) || (op == bod_pkg::op_incsnz)
      || (op == bod_pkg::op_tstsz);
  endfunction
  function automatic logic two_word(input bod_pkg::bod_op_t op);
    two_word = (op == bod_pkg::op_move2) || (op == bod_pkg::op_call)
      || (op == bod_pkg::op_goto) || (op == bod_pkg::op_lfsr);
  endfunction
  //////////////////////////////////////////////////////////////////////////
  logic [1:0] ctrl_ff;
  logic [3:0] bank_ff;
  logic [CNT_W-1:0] count_ff;
  logic [15:0] last_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  bod_pkg::bod_state_t state_ff;
  bod_pkg::bod_op_t op_ff;
  bod_pkg::bod_op_t first_op_ff;
  logic [11:0] first_addr_ff;
  logic first_fast_ff;
  logic flush_pend_ff;
  //////////////////////////////////////////////////////////////////////////
  wire logic req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;
  wire logic wr_take = avs_write & ack_ff;
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0;
    end else if (avs_read && !ack_ff) begin
      case (avs_address)
        `BOD_REG_CTRL: rdata_ff <= {30'h0, ctrl_ff};
        `BOD_REG_STAT: rdata_ff <= {23'h0, flush_pend_ff, state_ff, op_ff};
        `BOD_REG_COUNT: rdata_ff <= {{(32-CNT_W){1'b0}}, count_ff};
        `BOD_REG_BANK: rdata_ff <= {28'h0, bank_ff};
        `BOD_REG_LAST: rdata_ff <= {16'h0, last_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `BOD_CTRL_RST;
      bank_ff <= 4'h0;
    end else if (wr_take) begin
      if (avs_address == `BOD_REG_CTRL)
        ctrl_ff <= avs_writedata[1:0];
      if (avs_address == `BOD_REG_BANK)
        bank_ff <= avs_writedata[3:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // a taken test or pc change kills the next word
  wire logic flush_now = valid_out &
    (pc_mod(op_ff) | (cond_op(op_ff) & cond_true_in)) | flush_pend_ff; // RL17
  wire logic [15:0] w = instr_word_in;
  wire logic fetch = (state_ff == bod_pkg::st_fetch);
  wire logic kill = flush_now | ~ctrl_ff[`BOD_CTRL_EN];
  wire bod_pkg::bod_op_t nxt_op = kill ? bod_pkg::op_nop : dec_op(w);
  wire logic [7:0] f8 = w[`BOD_F_MSB:0]; // RL3
  wire logic [11:0] eff_addr = w[`BOD_A_BIT] ? {bank_ff, f8} : // RL2
    {(f8 >= `BOD_ACC_SPLIT) ? `BOD_ACC_HI_BANK : `BOD_ACC_LO_BANK, f8};
  wire logic nxt_dest = always_file(nxt_op) | (has_d(nxt_op) & w[`BOD_D_BIT]); // RL1
  wire logic in_access = ~w[`BOD_A_BIT];
  wire logic [PC_W-1:0] off11 = PC_W'({{(PC_W-11){w[`BOD_BRA_MSB]}},
    w[`BOD_BRA_MSB:0]}); // RL8
  wire logic [PC_W-1:0] off8 = PC_W'({{(PC_W-8){w[`BOD_F_MSB]}}, f8}); // RL9
  wire logic [PC_W-1:0] offs = (nxt_op == bod_pkg::op_bcond) ? off8 : off11;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n)
      flush_pend_ff <= 1'b0;
    else if (instr_valid_in && fetch)
      flush_pend_ff <= 1'b0;
    else if (flush_now)
      flush_pend_ff <= 1'b1;
  end
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= bod_pkg::st_fetch;
      first_op_ff <= bod_pkg::op_nop;
      first_addr_ff <= 12'h0;
      first_fast_ff <= 1'b0;
    end else if (instr_valid_in) begin
      if (!fetch) begin
        state_ff <= bod_pkg::st_fetch;
      end else if (two_word(nxt_op)) begin
        state_ff <= bod_pkg::st_second;
        first_op_ff <= nxt_op;
        first_addr_ff <= w[`BOD_LONG_MSB:0]; // RL4 RL7
        first_fast_ff <= w[`BOD_S_BIT]; // RL21
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
      last_ff <= 16'h0;
    end else if (instr_valid_in) begin
      count_ff <= count_ff + CNT_W'(1);
      last_ff <= w;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // first word of a pair shows as nop; the op comes out with its second word
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      valid_out <= 1'b0;
      op_ff <= bod_pkg::op_nop;
      dest_file_out <= 1'b0;
      file_addr_out <= 12'h0;
      bit_sel_out <= 3'h0;
      literal_out <= 8'h0;
      dst_addr_out <= 12'h0;
      target_out <= 20'h0;
      branch_target_out <= '0;
      flag_mask_out <= `BOD_FL_NONE;
      fast_out <= 1'b0;
      pins_source_out <= 1'b0;
      clear_prescaler_out <= 1'b0;
      product_write_out <= 1'b0;
      exec_nop_out <= 1'b0;
    end else begin
      valid_out <= instr_valid_in;
      pins_source_out <= 1'b0;
      clear_prescaler_out <= 1'b0;
      product_write_out <= 1'b0;
      fast_out <= 1'b0;
      exec_nop_out <= 1'b0;
      flag_mask_out <= `BOD_FL_NONE;
      if (instr_valid_in && !fetch) begin
        op_ff <= first_op_ff;
        dest_file_out <= 1'b1;
        file_addr_out <= first_addr_ff; // RL4
        dst_addr_out <= w[`BOD_LONG_MSB:0]; // RL4
        target_out <= {w[`BOD_LONG_MSB:0], first_addr_ff[`BOD_F_MSB:0]}; // RL7
        fast_out <= (first_op_ff == bod_pkg::op_call) & first_fast_ff; // RL21
        clear_prescaler_out <= (first_op_ff == bod_pkg::op_move2) &
          (w[`BOD_LONG_MSB:0] == {`BOD_ACC_HI_BANK, `BOD_TIMER0}) &
          ctrl_ff[`BOD_CTRL_PRESC]; // RL20
      end else if (instr_valid_in) begin
        op_ff <= two_word(nxt_op) ? bod_pkg::op_nop : nxt_op;
        exec_nop_out <= kill | (w[15:12] == `BOD_PREFIX); // RL17 RL18
        dest_file_out <= nxt_dest; // RL1
        file_addr_out <= eff_addr; // RL2
        bit_sel_out <= w[`BOD_B_MSB:`BOD_B_LSB]; // RL5
        literal_out <= f8; // RL6
        branch_target_out <= pc_in + (offs << 1); // RL22
        flag_mask_out <= flags_of(nxt_op);
        product_write_out <= (nxt_op == bod_pkg::op_mul); // RL23
        // latch and pin differ on input pins, so rmw must see the pins
        pins_source_out <= nxt_dest & in_access &
          (f8 >= `BOD_PORT_LO) & (f8 <= `BOD_PORT_HI); // RL19
        clear_prescaler_out <= nxt_dest & in_access & (f8 == `BOD_TIMER0) &
          ctrl_ff[`BOD_CTRL_PRESC]; // RL20
      end
    end
  end
  assign op_out = op_ff;
endmodule
`default_nettype wire

// *** testbench/bod_decoder_sva.sv ***
// concurrent checks on the decoder's ports
`timescale 1ns/1ps
`default_nettype none
`include "bod_regs.svh"
module bod_decoder_sva #(
  parameter int PC_W = 21
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [15:0] instr_word_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic valid_out,
  input wire logic [5:0] op_out,
  input wire logic dest_file_out,
  input wire logic [11:0] file_addr_out,
  input wire logic [PC_W-1:0] branch_target_out,
  input wire logic [4:0] flag_mask_out,
  input wire logic product_write_out,
  input wire logic exec_nop_out,
  input wire logic clear_prescaler_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] w_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] off;
  // copy of the word the decoder took, one cycle behind
  always_ff @(posedge clk_sys_in) begin
    w_ff <= instr_word_in;
    pc_ff <= pc_in;
  end
  assign off = {{(PC_W-12){w_ff[10]}}, w_ff[10:0], 1'b0};
  ////////////////////////////////////////////////////////////////////////////
  property p_dest;
    valid_out && op_out == bod_pkg::op_add |-> dest_file_out == $past(instr_word_in[9]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination bit wrong");
  property p_bank;
    valid_out && op_out == bod_pkg::op_add && !w_ff[8] |-> file_addr_out[11:8] ==
      (w_ff[7:0] < `BOD_ACC_SPLIT ? `BOD_ACC_LO_BANK : `BOD_ACC_HI_BANK);
  endproperty
  a_bank: assert property (p_bank) else $error("access bank mapping wrong");
  property p_faddr;
    valid_out && op_out == bod_pkg::op_sub |-> file_addr_out[7:0] == $past(instr_word_in[7:0]);
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address wrong");
  property p_arith;
    valid_out && op_out inside {bod_pkg::op_add, bod_pkg::op_addc, bod_pkg::op_incf,
      bod_pkg::op_decf, bod_pkg::op_neg} |-> flag_mask_out == `BOD_FL_ARITH;
  endproperty
  a_arith: assert property (p_arith) else $error("arith flags wrong");
  property p_logic;
    valid_out && op_out inside {bod_pkg::op_and, bod_pkg::op_or, bod_pkg::op_xor,
      bod_pkg::op_complement_file} |-> flag_mask_out == `BOD_FL_ZN;
  endproperty
  a_logic: assert property (p_logic) else $error("logic flags wrong");
  property p_skip;
    valid_out && op_out inside {[bod_pkg::op_cpeq:bod_pkg::op_cplt], bod_pkg::op_decsz,
      bod_pkg::op_decsnz, bod_pkg::op_incsz, bod_pkg::op_incsnz} |-> flag_mask_out == 5'h00;
  endproperty
  a_skip: assert property (p_skip) else $error("skip flags wrong");
  property p_rot;
    valid_out && op_out inside {[bod_pkg::op_rlc:bod_pkg::op_rrn]} |-> flag_mask_out ==
      (op_out inside {bod_pkg::op_rlc, bod_pkg::op_rrc} ? `BOD_FL_CZN : `BOD_FL_ZN);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate flags wrong");
  property p_sub;
    valid_out && op_out inside {[bod_pkg::op_sub:bod_pkg::op_subfb]} |-> flag_mask_out == 5'h1f;
  endproperty
  a_sub: assert property (p_sub) else $error("subtract flags wrong");
  property p_mul;
    valid_out && op_out == bod_pkg::op_mul |-> flag_mask_out == 5'h00 && product_write_out;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply decode wrong");
  property p_bra;
    valid_out && op_out == bod_pkg::op_bra |-> branch_target_out == pc_ff + off;
  endproperty
  a_bra: assert property (p_bra) else $error("branch target wrong");
  c_nop: cover property (valid_out && exec_nop_out);
  c_move: cover property (valid_out && op_out == bod_pkg::op_move2);
  c_presc: cover property (clear_prescaler_out);
endmodule
`default_nettype wire

// *** testbench/bod_prog_mem.sv ***
// program memory model presenting one word per fetch
`timescale 1ns/1ps
`default_nettype none
module bod_prog_mem (
  input wire logic clk_sys_in,
  input wire logic fetch_in,
  output logic [15:0] word_out,
  output logic valid_out
);
  logic [15:0] next_word;
  initial begin
    valid_out = 1'b0;
    word_out = 16'h0000;
  end
  // stale word inverted every idle cycle so a late sample never looks right
  always @(posedge clk_sys_in) begin
    valid_out <= fetch_in;
    word_out <= fetch_in ? next_word : ~word_out;
  end
endmodule
`default_nettype wire

// *** testbench/byte_op_instruction_decode_tb_top.sv ***
// self-checking bench of the byte-op decoder
`timescale 1ns/1ps
`default_nettype none
`include "bod_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module byte_op_instruction_decode_tb_top;
  localparam int PC_W = 21;
  logic clk_sys_in = 0, rst_n_in = 0, fetch = 0, cond_true_in = 0;
  logic [PC_W-1:0] pc_in = 0;
  logic [2:0] avs_address = 0;
  logic avs_read = 0, avs_write = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic avs_waitrequest, valid_out, dest_file_out, fast_out, pins_source_out;
  logic clear_prescaler_out, product_write_out, exec_nop_out, instr_valid_in;
  logic [15:0] instr_word_in;
  logic [5:0] op_out;
  logic [11:0] file_addr_out, dst_addr_out;
  logic [2:0] bit_sel_out;
  logic [7:0] literal_out;
  logic [19:0] target_out;
  logic [PC_W-1:0] branch_target_out;
  logic [4:0] flag_mask_out;
  int n_fail = 0, n_tests = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  bod_decoder #(.PC_W(PC_W)) dut_u (.clk_sys_in, .rst_n_in, .instr_word_in, .instr_valid_in,
    .pc_in, .cond_true_in, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .valid_out, .op_out, .dest_file_out, .file_addr_out, .bit_sel_out,
    .literal_out, .dst_addr_out, .target_out, .branch_target_out, .flag_mask_out, .fast_out,
    .pins_source_out, .clear_prescaler_out, .product_write_out, .exec_nop_out);
  bod_prog_mem pm_u (.clk_sys_in, .fetch_in(fetch), .word_out(instr_word_in),
    .valid_out(instr_valid_in));
  ////////////////////////////////////////////////////////////////////////////
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_sys_in);
    // request held until the edge that sees waitrequest low
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys_in);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // one word through the memory model; outputs settled on return
  task run(input logic [15:0] wd, input logic c);
    @(posedge clk_sys_in);
    fetch <= 1'b1;
    pm_u.next_word <= wd;
    @(posedge clk_sys_in);
    fetch <= 1'b0;
    @(posedge clk_sys_in);
    cond_true_in <= c;
    #1;
  endtask
  task t_regs;
    bus(1'b0, `BOD_REG_CTRL, 32'h0);
    `CHK(q[1:0], `BOD_CTRL_RST)
    bus(1'b1, `BOD_REG_BANK, 32'h5);
    bus(1'b0, `BOD_REG_BANK, 32'h0);
    `CHK(q[3:0], 4'h5)
    bus(1'b1, 3'h6, 32'hffff);
    bus(1'b0, 3'h6, 32'h0);
    `CHK(q, 32'h0)
  endtask
  task t_table;
    logic [15:0] w [24];
    logic [4:0] m [24];
    // listed in the package's op order, op_add upward
    w = '{16'h2623, 16'h2023, 16'h1423, 16'h1023, 16'h1823, 16'h1c23, 16'h6223, 16'h6423,
      16'h6023, 16'h0423, 16'h2c23, 16'h4c23, 16'h2823, 16'h3c23, 16'h4823, 16'h3623,
      16'h3023, 16'h4423, 16'h4023, 16'h5e23, 16'h5823, 16'h5423, 16'h0223, 16'h6c23};
    m = '{5'h1f, 5'h1f, 5'h03, 5'h03, 5'h03, 5'h03, 5'h00, 5'h00, 5'h00, 5'h1f, 5'h00, 5'h00,
      5'h1f, 5'h00, 5'h00, 5'h13, 5'h13, 5'h03, 5'h03, 5'h1f, 5'h1f, 5'h1f, 5'h00, 5'h1f};
    for (int i = 0; i < 24; i++) begin
      run(w[i], 1'b0);
      `CHK(op_out, 6'(i + 1))
      `CHK(flag_mask_out, m[i])
      `CHK(file_addr_out, 12'h023)
      `CHK(product_write_out, i == 22)
      `CHK(valid_out, 1'b1)
      if (i < 6) `CHK(dest_file_out, w[i][9])
    end
  endtask
  task t_bank;
    run(16'h2723, 1'b0);
    `CHK(file_addr_out, 12'h523)
    run(16'h245f, 1'b0);
    `CHK(file_addr_out, 12'h05f)
    run(16'h2680, 1'b0);
    `CHK(file_addr_out, 12'hf80)
    `CHK(pins_source_out, 1'b1)
    bus(1'b1, `BOD_REG_CTRL, 32'h3);
    run(16'h26d6, 1'b0);
    `CHK(clear_prescaler_out, 1'b1)
    run(16'hc023, 1'b0);
    run(16'hffd6, 1'b0);
    `CHK({op_out, clear_prescaler_out}, {bod_pkg::op_move2, 1'b1})
    bus(1'b1, `BOD_REG_CTRL, 32'h2);
    run(16'h26d6, 1'b0);
    `CHK(clear_prescaler_out, 1'b0)
  endtask
  task t_two_word;
    run(16'hc123, 1'b0);
    `CHK({op_out, exec_nop_out}, {bod_pkg::op_nop, 1'b0})
    run(16'hf456, 1'b0);
    `CHK({op_out, file_addr_out, dst_addr_out}, {bod_pkg::op_move2, 24'h123456})
    run(16'hef12, 1'b0);
    run(16'hf345, 1'b0);
    `CHK({op_out, target_out}, {bod_pkg::op_goto, 20'h34512})
    run(16'h2623, 1'b0);
    `CHK({op_out, exec_nop_out}, {bod_pkg::op_nop, 1'b1})
    run(16'hed12, 1'b0);
    run(16'hf000, 1'b0);
    `CHK({op_out, fast_out, target_out}, {bod_pkg::op_call, 21'h100012})
    // filler eats the flush left by the call
    run(16'hf000, 1'b0);
    `CHK({op_out, exec_nop_out}, {bod_pkg::op_nop, 1'b1})
    run(16'hec12, 1'b0);
    run(16'hf000, 1'b0);
    `CHK({op_out, fast_out}, {bod_pkg::op_call, 1'b0})
    run(16'hf000, 1'b0);
    run(16'hf123, 1'b0);
    `CHK({op_out, exec_nop_out}, {bod_pkg::op_nop, 1'b1})
  endtask
  task t_skip_branch;
    run(16'h6223, 1'b1);
    run(16'h2623, 1'b0);
    `CHK({op_out, exec_nop_out}, {bod_pkg::op_nop, 1'b1})
    run(16'h2623, 1'b0);
    `CHK(op_out, bod_pkg::op_add)
    @(posedge clk_sys_in);
    pc_in <= 21'h100;
    run(16'hd7ff, 1'b0);
    `CHK({op_out, branch_target_out}, {bod_pkg::op_bra, 21'h0fe})
    run(16'hd3ff, 1'b0);
    `CHK({op_out, exec_nop_out}, {bod_pkg::op_nop, 1'b1})
    run(16'hd3ff, 1'b0);
    `CHK(branch_target_out, 21'h8fe)
    run(16'he2fe, 1'b0);
    run(16'he2fe, 1'b0);
    `CHK({op_out, branch_target_out}, {bod_pkg::op_bcond, 21'h0fc})
    run(16'h0e7f, 1'b0);
    `CHK(literal_out, 8'h7f)
    run(16'h9a23, 1'b0);
    `CHK({op_out, bit_sel_out, file_addr_out}, {bod_pkg::op_bit, 3'h5, 12'h023})
  endtask
  task results;
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_regs;
    t_table;
    t_bank;
    t_two_word;
    t_skip_branch;
    results;
  end
  initial begin
    #50000;
    n_fail++;
    results;
  end
endmodule
bind bod_decoder bod_decoder_sva #(.PC_W(PC_W)) chk_u (.clk_sys_in, .rst_n_in, .instr_word_in,
  .pc_in, .valid_out, .op_out, .dest_file_out, .file_addr_out, .branch_target_out,
  .flag_mask_out, .product_write_out, .exec_nop_out, .clear_prescaler_out);
`default_nettype wire
